// [dbc_map.svh]
// Register map, field layout, reset values and timing counts of the converter control bank
// =============================================================================
// Function
// [RQ1] Per-converter discharge enable acts while converter is off; resets disabled.
// [RQ2] Power cycle reset forces discharge on both converters regardless of setting.
// [RQ3] Bank decodes at base 0x00000400; registers at their listed byte offsets.
// [RQ4] Writing one to bit zero at 0x0 requests converter one enable.
// [RQ5] Writing one to bit zero at 0x1 requests converter one disable.
// [RQ6] Writing one to bit zero at 0x2 requests converter two enable.
// [RQ7] Writing one to bit zero at 0x3 requests converter two disable.
// [RQ8] Writing one at 0x4 or 0x6 requests forced PWM entry.
// [RQ9] Writing one at 0x5 or 0x7 ends forced PWM, back to auto.
// [RQ10] Offset 0x8 holds converter one normal code, reset 0x02.
// [RQ11] Offset 0x9 holds converter one retention code, reset 0x02.
// [RQ12] Offset 0xA holds converter two normal code, reset 0x08.
// [RQ13] Offset 0xB holds converter two retention code, reset 0x08.
// [RQ14] Offsets 0x10 and 0x11 read back the voltage code actually applied.
// [RQ15] GPIO selects for enable 0xC, retention 0xD, forced PWM 0xE, both converters.
// [RQ16] Offset 0x15 selects auto or PFM only and holds discharge enables.
// [RQ17] Host writes software select after a new code so it beats the strap.
// [RQ18] Enable and disable requests override the automatic on or off state.
// [RQ19] A GPIO chosen for forced PWM overrides the register-requested PWM setting.
// [RQ20] Set and clear for one function in one write: clear wins.
`ifndef DBC_MAP_SVH
`define DBC_MAP_SVH

// =============================================================================
// Addressing
`define DBC_BASE_ADDR 32'h0000_0400
`define DBC_OFS_C1_EN_SET 8'h00
`define DBC_OFS_C1_EN_CLR 8'h01
`define DBC_OFS_C2_EN_SET 8'h02
`define DBC_OFS_C2_EN_CLR 8'h03
`define DBC_OFS_C1_PWM_SET 8'h04
`define DBC_OFS_C1_PWM_CLR 8'h05
`define DBC_OFS_C2_PWM_SET 8'h06
`define DBC_OFS_C2_PWM_CLR 8'h07
`define DBC_OFS_C1_NORM 8'h08
`define DBC_OFS_C1_RET 8'h09
`define DBC_OFS_C2_NORM 8'h0a
`define DBC_OFS_C2_RET 8'h0b
`define DBC_OFS_EN_GPIO 8'h0c
`define DBC_OFS_RET_GPIO 8'h0d
`define DBC_OFS_PWM_GPIO 8'h0e
`define DBC_OFS_SW_SEL 8'h0f
`define DBC_OFS_C1_VSTAT 8'h10
`define DBC_OFS_C2_VSTAT 8'h11
`define DBC_OFS_MODE_DIS 8'h15
`define DBC_OFS_STATUS 8'h34

// =============================================================================
// Reset values
`define DBC_RST_C1_CODE 5'h02
`define DBC_RST_C2_CODE 5'h08
`define DBC_RST_SEL 8'h00

// =============================================================================
// Field positions
`define DBC_GSEL_C1_LSB 0
`define DBC_GSEL_C2_LSB 3
`define DBC_GSEL_C1_INV 6
`define DBC_GSEL_C2_INV 7
`define DBC_MD_PFM_LSB 0
`define DBC_MD_DIS_LSB 2
`define DBC_CODE_MAX 5'h18

// =============================================================================
// Timing: cycles from reset release until pin samples are settled
`define DBC_SETTLE_CYCLES 3'h4

`endif

// [dbc_pkg.sv]
// Types shared by the converter control bank
package dbc_pkg;

  typedef logic [4:0] dbc_code_t;

  typedef enum logic [1:0] {
    DBC_MODE_AUTO = 2'h0,
    DBC_MODE_PFM = 2'h1,
    DBC_MODE_PWM = 2'h2
  } dbc_mode_e;

  typedef enum logic [2:0] {
    DBC_ST_W0 = 3'h0,
    DBC_ST_W1 = 3'h1,
    DBC_ST_W2 = 3'h3,
    DBC_ST_W3 = 3'h2,
    DBC_ST_RUN = 3'h6
  } dbc_state_e;

endpackage : dbc_pkg

// [dbc_regs.sv]
// Control and status register bank for two step-down converters
`timescale 1ns/1ps
`include "dbc_map.svh"

module dbc_regs
  import dbc_pkg::*;
#(
  parameter int NCONV = 2,
  parameter int NGPIO = 5
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic [31:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic [NGPIO-1:0] gpio_pin,
  input wire logic power_cycle_pin,
  input wire logic conv1_strap_pin_on,
  input wire logic [4:0] conv1_strap_pin_code,
  input wire logic conv2_strap_pin_on,
  input wire logic [4:0] conv2_strap_pin_code,
  output logic [1:0] conv_enable,
  output logic [1:0] conv_forced_pwm,
  output logic [1:0] conv_pfm_only,
  output logic [4:0] conv1_voltage_code,
  output logic [4:0] conv2_voltage_code,
  output logic [1:0] conv_discharge
);

  localparam int NPIN = NGPIO + 13;

  // =============================================================================
  // Pin synchronisers: a change counts once stages two and three agree
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_s1;
  logic [NPIN-1:0] pin_s2;
  logic [NPIN-1:0] pin_s3;
  logic [NPIN-1:0] pin_f;

  assign pin_raw = {power_cycle_pin, gpio_pin, conv2_strap_pin_on, conv1_strap_pin_on,
                    conv2_strap_pin_code, conv1_strap_pin_code};

  logic [NPIN-1:0] next_pin_f;

  always_comb begin
    next_pin_f = pin_f;
    for (int i = 0; i < NPIN; i++) begin
      if (pin_s2[i] == pin_s3[i]) begin
        next_pin_f[i] = pin_s3[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_s3 <= '0;
    end else if (ce) begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pin_f <= '0;
    end else if (ce) begin
      pin_f <= next_pin_f;
    end
  end

  logic [NGPIO-1:0] gpio_f;
  logic power_cycle_f;
  dbc_code_t strap_code [NCONV];
  logic [1:0] strap_on_f;

  assign gpio_f = pin_f[NGPIO+11:12];
  assign power_cycle_f = pin_f[NPIN-1];
  // Straps use the filter's next value: the filtered copy settles one edge after capture
  assign strap_code[0] = next_pin_f[4:0];
  assign strap_code[1] = next_pin_f[9:5];
  assign strap_on_f = next_pin_f[11:10];

  // =============================================================================
  // Start-up: straps are read once the synchronisers have settled
  dbc_state_e state;
  dbc_state_e next_state;
  logic [1:0] strap_on;
  dbc_code_t strap_val [NCONV];

  always_comb begin
    next_state = state;
    unique case (state)
      DBC_ST_W0: next_state = DBC_ST_W1;
      DBC_ST_W1: next_state = DBC_ST_W2;
      DBC_ST_W2: next_state = DBC_ST_W3;
      DBC_ST_W3: next_state = DBC_ST_RUN;
      DBC_ST_RUN: next_state = DBC_ST_RUN;
      default: next_state = DBC_ST_W0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= DBC_ST_W0;
    end else if (ce) begin
      state <= next_state;
    end
  end

  // Straps are power-on only; later pin changes are ignored
  always_ff @(posedge clk) begin
    if (reset) begin
      strap_on <= 2'h0;
      strap_val[0] <= `DBC_RST_C1_CODE;
      strap_val[1] <= `DBC_RST_C2_CODE;
    end else if (ce && state == DBC_ST_W3) begin
      strap_on <= strap_on_f;
      strap_val[0] <= strap_code[0];
      strap_val[1] <= strap_code[1];
    end
  end

  // =============================================================================
  // Address decode
  logic hit;
  logic [7:0] ofs;
  logic [31:0] rel_addr;
  logic wr_en;

  assign rel_addr = reg_addr - `DBC_BASE_ADDR; // [RQ3]
  assign hit = (rel_addr[31:8] == 24'h0);
  assign ofs = rel_addr[7:0];
  assign wr_en = ce && reg_wr && hit;

  function automatic logic wr_one(input logic [7:0] o);
    wr_one = wr_en && ofs == o && reg_wdata[0];
  endfunction : wr_one

  logic [1:0] en_set;
  logic [1:0] en_clr;
  logic [1:0] pwm_set;
  logic [1:0] pwm_clr;

  // Procedural, so the decode follows the bus signals that wr_one reads
  always_comb begin
    en_set = {wr_one(`DBC_OFS_C2_EN_SET), wr_one(`DBC_OFS_C1_EN_SET)}; // [RQ4] [RQ6]
    en_clr = {wr_one(`DBC_OFS_C2_EN_CLR), wr_one(`DBC_OFS_C1_EN_CLR)}; // [RQ5] [RQ7]
    pwm_set = {wr_one(`DBC_OFS_C2_PWM_SET), wr_one(`DBC_OFS_C1_PWM_SET)}; // [RQ8]
    pwm_clr = {wr_one(`DBC_OFS_C2_PWM_CLR), wr_one(`DBC_OFS_C1_PWM_CLR)}; // [RQ9]
  end

  // =============================================================================
  // Stored registers
  dbc_code_t norm_code [NCONV];
  dbc_code_t ret_code [NCONV];
  logic [7:0] en_gsel;
  logic [7:0] ret_gsel;
  logic [7:0] pwm_gsel;
  logic [1:0] sw_sel;
  logic [3:0] mode_dis;

  always_ff @(posedge clk) begin
    if (reset) begin
      norm_code[0] <= `DBC_RST_C1_CODE; // [RQ10]
      ret_code[0] <= `DBC_RST_C1_CODE; // [RQ11]
      norm_code[1] <= `DBC_RST_C2_CODE; // [RQ12]
      ret_code[1] <= `DBC_RST_C2_CODE; // [RQ13]
    end else if (wr_en) begin
      if (ofs == `DBC_OFS_C1_NORM) norm_code[0] <= reg_wdata[4:0]; // [RQ10]
      if (ofs == `DBC_OFS_C1_RET) ret_code[0] <= reg_wdata[4:0]; // [RQ11]
      if (ofs == `DBC_OFS_C2_NORM) norm_code[1] <= reg_wdata[4:0]; // [RQ12]
      if (ofs == `DBC_OFS_C2_RET) ret_code[1] <= reg_wdata[4:0]; // [RQ13]
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      en_gsel <= `DBC_RST_SEL;
      ret_gsel <= `DBC_RST_SEL;
      pwm_gsel <= `DBC_RST_SEL;
    end else if (wr_en) begin
      if (ofs == `DBC_OFS_EN_GPIO) en_gsel <= reg_wdata; // [RQ15]
      if (ofs == `DBC_OFS_RET_GPIO) ret_gsel <= reg_wdata; // [RQ15]
      if (ofs == `DBC_OFS_PWM_GPIO) pwm_gsel <= reg_wdata; // [RQ15]
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sw_sel <= 2'h0;
      mode_dis <= 4'h0; // [RQ1]
    end else if (wr_en) begin
      if (ofs == `DBC_OFS_SW_SEL) sw_sel <= reg_wdata[1:0]; // [RQ17]
      if (ofs == `DBC_OFS_MODE_DIS) mode_dis <= reg_wdata[3:0]; // [RQ16]
    end
  end

  // =============================================================================
  // GPIO selection: codes 1 to 5 pick a pin, others leave the function to software
  function automatic logic [1:0] gpio_pick(input logic [2:0] sel, input logic inv,
                                           input logic [NGPIO-1:0] g);
    logic [2:0] idx;
    idx = sel - 3'h1;
    if (sel >= 3'h1 && sel <= 3'(NGPIO)) begin
      gpio_pick = {1'b1, g[idx] ^ inv};
    end else begin
      gpio_pick = 2'h0;
    end
  endfunction : gpio_pick

  logic [1:0] en_g [NCONV];
  logic [1:0] ret_g [NCONV];
  logic [1:0] pwm_g [NCONV];

  always_comb begin
    en_g[0] = gpio_pick(en_gsel[2:0], en_gsel[`DBC_GSEL_C1_INV], gpio_f); // [RQ15]
    en_g[1] = gpio_pick(en_gsel[5:3], en_gsel[`DBC_GSEL_C2_INV], gpio_f);
    ret_g[0] = gpio_pick(ret_gsel[2:0], ret_gsel[`DBC_GSEL_C1_INV], gpio_f);
    ret_g[1] = gpio_pick(ret_gsel[5:3], ret_gsel[`DBC_GSEL_C2_INV], gpio_f);
    pwm_g[0] = gpio_pick(pwm_gsel[2:0], pwm_gsel[`DBC_GSEL_C1_INV], gpio_f);
    pwm_g[1] = gpio_pick(pwm_gsel[5:3], pwm_gsel[`DBC_GSEL_C2_INV], gpio_f);
  end

  // =============================================================================
  // Enable and forced-PWM latches; the clear is tested last so it wins
  logic [1:0] en_latch;
  logic [1:0] pwm_latch;

  always_ff @(posedge clk) begin
    if (reset) begin
      en_latch <= 2'h0;
    end else if (ce) begin
      // Start-up load replaces any pulse, so requests only count once running
      if (state == DBC_ST_W3) begin
        en_latch <= strap_on_f;
      end else begin
        for (int c = 0; c < NCONV; c++) begin
          if (en_set[c]) en_latch[c] <= 1'b1; // [RQ18]
          if (en_clr[c]) en_latch[c] <= 1'b0; // [RQ20]
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pwm_latch <= 2'h0;
    end else if (ce) begin
      for (int c = 0; c < NCONV; c++) begin
        if (pwm_set[c]) pwm_latch[c] <= 1'b1; // [RQ8]
        if (pwm_clr[c]) pwm_latch[c] <= 1'b0; // [RQ9] [RQ20]
      end
    end
  end

  // =============================================================================
  // Outputs to the converters
  dbc_code_t applied [NCONV];
  logic [1:0] next_en;
  logic [1:0] next_pwm;

  always_comb begin
    for (int c = 0; c < NCONV; c++) begin
      next_en[c] = en_g[c][1] ? en_g[c][0] : en_latch[c];
      next_pwm[c] = pwm_g[c][1] ? pwm_g[c][0] : pwm_latch[c]; // [RQ19]
      // A converter off at power-up falls to software control
      if (sw_sel[c] || !strap_on[c]) begin
        applied[c] = (ret_g[c][1] && ret_g[c][0]) ? ret_code[c] : norm_code[c];
      end else begin
        applied[c] = strap_val[c];
      end
    end
  end

  // Enable held low through start-up so a converter never starts before its strap is read
  always_ff @(posedge clk) begin
    if (reset) begin
      conv_enable <= 2'h0;
    end else if (ce) begin
      conv_enable <= (state == DBC_ST_RUN) ? next_en : 2'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      conv_forced_pwm <= 2'h0;
      conv_pfm_only <= 2'h0;
    end else if (ce) begin
      conv_forced_pwm <= next_pwm;
      conv_pfm_only <= mode_dis[`DBC_MD_PFM_LSB +: 2] & ~next_pwm; // [RQ16]
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      conv1_voltage_code <= `DBC_RST_C1_CODE;
      conv2_voltage_code <= `DBC_RST_C2_CODE;
    end else if (ce) begin
      conv1_voltage_code <= applied[0]; // [RQ14]
      conv2_voltage_code <= applied[1]; // [RQ14]
    end
  end

  // Discharge held on through reset and any pin-signalled power cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      conv_discharge <= 2'h3; // [RQ2]
    end else if (ce) begin
      if (power_cycle_f || state != DBC_ST_RUN) begin
        conv_discharge <= 2'h3; // [RQ2]
      end else begin
        conv_discharge <= mode_dis[`DBC_MD_DIS_LSB +: 2] & ~next_en; // [RQ1]
      end
    end
  end

  // =============================================================================
  // Read path; write-only and unmapped offsets read zero
  logic [7:0] rd_mux;

  function automatic logic [1:0] mode_of(input logic pwm, input logic pfm);
    mode_of = pwm ? DBC_MODE_PWM : (pfm ? DBC_MODE_PFM : DBC_MODE_AUTO);
  endfunction : mode_of

  always_comb begin
    rd_mux = 8'h00;
    if (hit) begin
      unique case (ofs)
        `DBC_OFS_C1_NORM: rd_mux = {3'h0, norm_code[0]};
        `DBC_OFS_C1_RET: rd_mux = {3'h0, ret_code[0]};
        `DBC_OFS_C2_NORM: rd_mux = {3'h0, norm_code[1]};
        `DBC_OFS_C2_RET: rd_mux = {3'h0, ret_code[1]};
        `DBC_OFS_EN_GPIO: rd_mux = en_gsel;
        `DBC_OFS_RET_GPIO: rd_mux = ret_gsel;
        `DBC_OFS_PWM_GPIO: rd_mux = pwm_gsel;
        `DBC_OFS_SW_SEL: rd_mux = {6'h0, sw_sel};
        `DBC_OFS_C1_VSTAT: rd_mux = {3'h0, conv1_voltage_code}; // [RQ14]
        `DBC_OFS_C2_VSTAT: rd_mux = {3'h0, conv2_voltage_code}; // [RQ14]
        `DBC_OFS_MODE_DIS: rd_mux = {4'h0, mode_dis}; // [RQ16]
        `DBC_OFS_STATUS: rd_mux = {conv_forced_pwm[1], conv_enable[1],
                                   mode_of(conv_forced_pwm[1], conv_pfm_only[1]),
                                   conv_forced_pwm[0], conv_enable[0],
                                   mode_of(conv_forced_pwm[0], conv_pfm_only[0])};
        default: rd_mux = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rvalid <= 1'b0;
    end else if (ce) begin
      reg_rvalid <= reg_rd;
    end
  end

  // Data holds between reads so a slow host may still pick it up late
  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (ce && reg_rd) begin
      reg_rdata <= rd_mux;
    end
  end

endmodule : dbc_regs

// [dbc_regs_properties.sv]
// Port-level checks of the converter control bank
`timescale 1ns/1ps
module dbc_regs_properties (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic [31:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic power_cycle_pin,
  input wire logic [1:0] conv_enable,
  input wire logic [1:0] conv_forced_pwm,
  input wire logic [1:0] conv_pfm_only,
  input wire logic [4:0] conv1_voltage_code,
  input wire logic [1:0] conv_discharge
);
  // ==========
  // Shadow selects; pulses are judged only after start-up, since strap capture overwrites enable pulses
  logic [2:0] run_cnt;
  logic [7:0] en_sel;
  logic [7:0] pwm_sel;
  logic go;
  assign go = run_cnt == 3'h7;
  always_ff @(posedge clk) begin
    if (reset) run_cnt <= 3'h0;
    else if (ce && !go) run_cnt <= run_cnt + 3'h1;
  end
  always_ff @(posedge clk) begin
    if (reset) en_sel <= 8'h00;
    else if (ce && reg_wr && reg_addr == 32'h40c) en_sel <= reg_wdata;
  end
  always_ff @(posedge clk) begin
    if (reset) pwm_sel <= 8'h00;
    else if (ce && reg_wr && reg_addr == 32'h40e) pwm_sel <= reg_wdata;
  end
  // ==========
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_pulse(logic [31:0] a);
    go && ce && reg_wr && reg_addr == a && reg_wdata[0];
  endsequence
  property p_rvalid; ce && reg_rd |=> reg_rvalid; endproperty
  a_rvalid: assert property (p_rvalid) else $error("read answer missing");
  property p_idle; ce && !reg_rd |=> !reg_rvalid; endproperty
  a_idle: assert property (p_idle) else $error("stray read answer");
  property p_outside; ce && reg_rd && reg_addr[31:8] != 24'h4 |=> reg_rdata == 8'h00; endproperty
  a_outside: assert property (p_outside) else $error("outside read not zero");
  property p_wo; ce && reg_rd && reg_addr[31:3] == 29'h80 |=> reg_rdata == 8'h00; endproperty
  a_wo: assert property (p_wo) else $error("pulse register read not zero");
  property p_status;
    ce && reg_rd && reg_addr == 32'h410 |=> reg_rdata == {3'h0, $past(conv1_voltage_code)};
  endproperty
  a_status: assert property (p_status) else $error("status differs from code");
  property p_reset;
    @(posedge clk) disable iff (1'b0) reset && ce |=> conv_discharge == 2'h3 && !conv_enable;
  endproperty
  a_reset: assert property (p_reset) else $error("reset outputs wrong");
  property p_on; s_pulse(32'h400) ##0 en_sel[2:0] == 3'h0 |=> ##1 conv_enable[0]; endproperty
  a_on: assert property (p_on) else $error("enable pulse ignored");
  property p_off; s_pulse(32'h401) ##0 en_sel[2:0] == 3'h0 |=> ##1 !conv_enable[0]; endproperty
  a_off: assert property (p_off) else $error("disable pulse ignored");
  property p_fpwm;
    s_pulse(32'h404) ##0 pwm_sel[2:0] == 3'h0 |=> ##1 conv_forced_pwm[0];
  endproperty
  a_fpwm: assert property (p_fpwm) else $error("forced pwm ignored");
  property p_auto;
    s_pulse(32'h405) ##0 pwm_sel[2:0] == 3'h0 |=> ##1 !conv_forced_pwm[0];
  endproperty
  a_auto: assert property (p_auto) else $error("auto request ignored");
  property p_pfm; conv_forced_pwm[0] |-> !conv_pfm_only[0]; endproperty
  a_pfm: assert property (p_pfm) else $error("pfm with forced pwm");
  property p_pcyc; power_cycle_pin [*8] |-> conv_discharge == 2'h3; endproperty
  a_pcyc: assert property (p_pcyc) else $error("power cycle discharge off");
endmodule : dbc_regs_properties

bind dbc_regs dbc_regs_properties u_props (
  .clk, .reset, .ce, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .reg_rvalid,
  .power_cycle_pin, .conv_enable, .conv_forced_pwm, .conv_pfm_only, .conv1_voltage_code,
  .conv_discharge
);

// [testbench.sv]
// Self-checking bench of the converter control bank
`timescale 1ns/1ps
module testbench;
  // ==========
  // Stimulus and bookkeeping
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic ce = 1'b1;
  logic [31:0] reg_addr = 32'h400;
  logic reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic [4:0] gpio_pin = 5'h00;
  logic pcyc = 1'b0;
  logic [1:0] s_on = 2'h3;
  logic [4:0] s1_code = 5'h05;
  logic [4:0] s2_code = 5'h0a;
  logic [1:0] en;
  logic [1:0] pwm;
  logic [1:0] pfm;
  logic [1:0] dis;
  logic [4:0] v1;
  logic [4:0] v2;
  logic [7:0] st;
  logic [31:0] seed = 32'h7f53;
  int error_cnt = 0;
  int samples_checked = 0;
  logic [7:0] rw_ofs [9] = '{8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h15};
  logic [31:0] bad [4] = '{32'h412, 32'h413, 32'h3ff, 32'h500};
  assign st = {dis, pfm, pwm, en};

  dbc_regs dut (
    .clk(clk), .reset(reset), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .gpio_pin(gpio_pin), .power_cycle_pin(pcyc), .conv1_strap_pin_on(s_on[0]),
    .conv1_strap_pin_code(s1_code), .conv2_strap_pin_on(s_on[1]),
    .conv2_strap_pin_code(s2_code), .conv_enable(en), .conv_forced_pwm(pwm),
    .conv_pfm_only(pfm), .conv1_voltage_code(v1), .conv2_voltage_code(v2),
    .conv_discharge(dis)
  );

  initial begin
    forever #2.5 clk = ~clk;
  end

  function automatic logic [31:0] nxt();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : nxt
  function automatic logic [7:0] rmask(input logic [7:0] o);
    if (o < 8'h0c) return 8'h1f;
    if (o == 8'h0f) return 8'h03;
    return (o == 8'h15) ? 8'h0f : 8'hff;
  endfunction : rmask
  function automatic logic [7:0] rst_val(input logic [7:0] o);
    return (o < 8'h0a) ? 8'h02 : (o < 8'h0c) ? 8'h08 : 8'h00;
  endfunction : rst_val

  // ==========
  // Bus cycles and comparison
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic conclude();
    $display("Checks %0d, errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude
  task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %0t: %s got %h expected %h", $time, m, g, e);
    end
  endtask : chk
  // Strobe is dropped and one edge left idle, so back-to-back calls never retouch it
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick(1);
    reg_wr = 1'b0;
    tick(1);
  endtask : wr
  task automatic rd(input logic [31:0] a, output logic [7:0] d);
    reg_addr = a;
    reg_rd = 1'b1;
    tick(1);
    reg_rd = 1'b0;
    for (int k = 0; k < 4 && reg_rvalid !== 1'b1; k++) tick(1);
    if (reg_rvalid !== 1'b1) begin
      error_cnt++;
      $display("Error %0t: no read answer", $time);
      conclude();
    end
    d = reg_rdata;
  endtask : rd
  task automatic wchk(input logic [31:0] a, input logic [7:0] d, input int b, input logic e);
    wr(a, d);
    tick(1);
    chk({7'h0, st[b]}, {7'h0, e}, "output after write");
  endtask : wchk

  // ==========
  // Scenarios
  initial begin
    logic [7:0] d;
    logic [7:0] v;
    s1_code = 5'(nxt() % 25);
    s2_code = 5'(nxt() % 25);
    tick(10);
    reset = 1'b0;
    chk({6'h0, dis}, 8'h03, "discharge at reset");
    tick(8);
    chk({6'h0, en}, 8'h03, "strap enable");
    foreach (rw_ofs[k]) begin
      rd(32'h400 + rw_ofs[k], d);
      chk(d, rst_val(rw_ofs[k]), "reset value");
    end
    $display("test reset values done");
    for (int k = 0; k < 8; k++) begin
      rd(32'h400 + k, d);
      chk(d, 8'h00, "pulse register read");
    end
    wr(32'h412, 8'hff);
    foreach (bad[k]) begin
      rd(bad[k], d);
      chk(d, 8'h00, "unmapped read");
    end
    $display("test decode done");
    repeat (3) foreach (rw_ofs[k]) begin
      gpio_pin = 5'(nxt());
      v = 8'(nxt());
      if (k < 4) v = v % 8'd25;
      wr(32'h400 + rw_ofs[k], v);
      rd(32'h400 + rw_ofs[k], d);
      chk(d, v & rmask(rw_ofs[k]), "read back");
    end
    gpio_pin = 5'h00;
    foreach (rw_ofs[k]) if (k > 3) wr(32'h400 + rw_ofs[k], 8'h00);
    $display("test read write done");
    for (int i = 0; i < 2; i++) begin
      wchk(32'h401 + 2 * i, 8'h01, i, 1'b0);
      wchk(32'h400 + 2 * i, 8'hfe & 8'(nxt()), i, 1'b0);
      wchk(32'h400 + 2 * i, 8'h01, i, 1'b1);
      wchk(32'h404 + 2 * i, 8'h01, 2 + i, 1'b1);
      wchk(32'h405 + 2 * i, 8'h01, 2 + i, 1'b0);
      wchk(32'h415, 8'h03, 4 + i, 1'b1);
      wchk(32'h404 + 2 * i, 8'h01, 4 + i, 1'b0);
      wchk(32'h405 + 2 * i, 8'h01, 4 + i, 1'b1);
      wchk(32'h415, 8'h0c, 6 + i, 1'b0);
      wchk(32'h401 + 2 * i, 8'h01, 6 + i, 1'b1);
      wchk(32'h415, 8'h00, 6 + i, 1'b0);
      wchk(32'h400 + 2 * i, 8'h01, i, 1'b1);
    end
    $display("test pulses done");
    wr(32'h40e, 8'h01);
    gpio_pin = 5'h01;
    tick(8);
    chk({7'h0, st[2]}, 8'h01, "pin forced pwm");
    wchk(32'h405, 8'h01, 2, 1'b1);
    wr(32'h40e, 8'h88);
    gpio_pin = 5'h00;
    tick(8);
    chk({6'h0, st[3:2]}, 8'h02, "inverted pin pwm");
    rd(32'h434, d);
    chk(d, 8'he4, "status with forced pwm");
    wr(32'h40e, 8'h00);
    wr(32'h40c, 8'h42);
    gpio_pin = 5'h02;
    tick(8);
    chk({6'h0, en}, 8'h02, "pin enable");
    wr(32'h40c, 8'h00);
    gpio_pin = 5'h00;
    $display("test pwm pin done");
    for (int n = 0; n < 4; n++) begin
      v = (n == 0) ? 8'h00 : (n == 1) ? 8'h18 : 8'(nxt() % 25);
      wr(32'h408, v);
      wr(32'h40a, 8'h18 - v);
      if (n == 0) begin
        rd(32'h410, d);
        chk(d, {3'h0, s1_code}, "strap code one");
        rd(32'h411, d);
        chk(d, {3'h0, s2_code}, "strap code two");
        wr(32'h40f, 8'h03);
      end
      tick(1);
      rd(32'h410, d);
      chk(d, v, "status one");
      rd(32'h411, d);
      chk(d, 8'h18 - v, "status two");
    end
    ce = 1'b0;
    wr(32'h408, v ^ 8'h01);
    ce = 1'b1;
    rd(32'h408, d);
    chk(d, v, "write while frozen");
    wr(32'h409, 8'h13);
    wr(32'h40d, 8'h01);
    gpio_pin = 5'h01;
    tick(8);
    rd(32'h410, d);
    chk(d, 8'h13, "retention code");
    gpio_pin = 5'h00;
    $display("test voltage done");
    pcyc = 1'b1;
    tick(8);
    chk({6'h0, dis}, 8'h03, "power cycle");
    pcyc = 1'b0;
    $display("test power cycle done");
    conclude();
  end
endmodule : testbench
